/* File: eag_pkg.sv */
// constants and types shared by the effective address generator
// assumes one 50 MHz clock domain shared with decoder and register file
// Summary of operation
// (RULE_01) direct mode: operand is the register itself
// (RULE_02) indirect mode: address is register unchanged
// (RULE_03) post-increment: old value addressed, then add size
// (RULE_04) pre-decrement: subtract size, use and store result
// (RULE_05) register plus zero-extended scaled 4-bit displacement
// (RULE_06) indexed: register plus index register zero
// (RULE_07) base plus zero-extended scaled 8-bit displacement
// (RULE_08) indexed base: base plus index register zero
// (RULE_09) pc data: zero-extended 8-bit displacement, scaled
// (RULE_10) longword pc data masks low two pc bits
// (RULE_11) short branch: sign-extended 8-bit times two
// (RULE_12) long branch: sign-extended 12-bit times two
// (RULE_13) register branch: pc plus selected register
// (RULE_14) test and logic immediates zero-extended
// (RULE_15) move, add, compare immediates sign-extended
// (RULE_16) trap immediate zero-extended times four
// (RULE_17) byte or word loads sign-extended to 32 bits
// (RULE_18) address arithmetic wraps modulo 32 bits
package eag_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int DATA_W = 32;
  localparam int DISP4_W = 4;
  localparam int DISP8_W = 8;
  localparam int DISP12_W = 12;
  localparam int IMM_W = 8;

  // ****************************************
  // arithmetic constants
  // ****************************************
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] LONG_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam int BRANCH_SHIFT = 1;
  localparam int TRAP_SHIFT = 2;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_t;

  typedef enum logic [3:0] {
    MODE_DIRECT, MODE_INDIRECT, MODE_POSTINC, MODE_PREDEC,
    MODE_REG_DISP, MODE_REG_INDEXED, MODE_BASE_DISP,
    MODE_BASE_INDEXED, MODE_PC_DATA, MODE_BRANCH_SHORT,
    MODE_BRANCH_LONG, MODE_BRANCH_REG, MODE_IMM_ZERO,
    MODE_IMM_SIGN, MODE_IMM_TRAP
  } mode_t;

endpackage

/* File: disp_scaler.sv */
// zero-extends a displacement and scales it by access size
// assumes size is valid; pc data mode never uses the byte scale
`timescale 1ns/1ns
module disp_scaler #(
  parameter int IN_W = 8
) (
  // displacement and size
  input wire logic [IN_W-1:0] disp,
  input wire eag_pkg::size_t size,
  input wire logic pc_data,
  // result
  output logic [31:0] scaled
);
  import eag_pkg::*;

  // shift by two must still fit in the 32-bit result
  if (IN_W < 1 || IN_W > 24)
  begin : width_check
    $error("disp_scaler: IN_W out of range");
  end

  logic [31:0] wide;
  assign wide = {{(32-IN_W){1'b0}}, disp};

  // byte scale is one, except pc data which has no byte form
  always_comb
  begin
    case (size)
      SIZE_BYTE: scaled = pc_data ? (wide << 1) : wide;
      SIZE_WORD: scaled = wide << 1;
      SIZE_LONG: scaled = wide << 2;
      default: scaled = wide;
    endcase
  end

endmodule // disp_scaler

/* File: load_extender.sv */
// sign-extends byte or word load data to a full longword
// assumes byte data in bits 7:0 and word data in bits 15:0
`timescale 1ns/1ns
module load_extender (
  // raw data
  input wire logic [31:0] data,
  input wire eag_pkg::size_t size,
  // extended data
  output logic [31:0] ext
);
  import eag_pkg::*;

  // longword passes unchanged
  always_comb
  begin
    case (size)
      SIZE_BYTE: ext = {{24{data[7]}}, data[7:0]}; // RULE_17
      SIZE_WORD: ext = {{16{data[15]}}, data[15:0]}; // RULE_17
      default: ext = data;
    endcase
  end

endmodule // load_extender

/* File: effective_address_generator.sv */
// effective address and operand former for the core pipeline
// assumes decoder presents one request per cycle with register values
// already read; results appear one clock after the request
`timescale 1ns/1ns
module effective_address_generator #(
  parameter int DATA_WIDTH = eag_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request from decoder
  input wire logic req_valid,
  input wire eag_pkg::mode_t mode,
  input wire eag_pkg::size_t size,
  input wire logic [11:0] disp_field,
  input wire logic [7:0] imm_field,
  // register file values
  input wire logic [31:0] selected_general_register,
  input wire logic [31:0] index_register_zero,
  input wire logic [31:0] global_base_register,
  input wire logic [31:0] pc,
  // load data from memory
  input wire logic load_valid,
  input wire eag_pkg::size_t load_size,
  input wire logic [31:0] load_data,
  // address result
  output logic result_valid,
  output logic mem_access,
  output logic branch_valid,
  output logic [31:0] address,
  // operand result
  output logic operand_valid,
  output logic [31:0] operand,
  // register write back
  output logic writeback_valid,
  output logic [31:0] writeback_value,
  // extended load
  output logic load_word_valid,
  output logic [31:0] load_word
);
  import eag_pkg::*;

  if (DATA_WIDTH != 32)
  begin : width_check
    $error("effective_address_generator: only 32-bit data");
  end

  // ****************************************
  // size step and displacement scaling
  // ****************************************
  logic [31:0] step;
  logic [31:0] scaled4;
  logic [31:0] scaled8;
  logic [31:0] branch8;
  logic [31:0] branch12;
  logic [31:0] pc_base;
  logic [31:0] load_ext;
  logic pc_data_mode;

  // step used by post-increment and pre-decrement
  always_comb
  begin
    case (size)
      SIZE_BYTE: step = STEP_BYTE;
      SIZE_WORD: step = STEP_WORD;
      SIZE_LONG: step = STEP_LONG;
      default: step = STEP_BYTE;
    endcase
  end

  assign pc_data_mode = (mode == MODE_PC_DATA);

  // short displacement for register relative access
  disp_scaler #(
    .IN_W(DISP4_W)
  ) scale_short (
    .disp(disp_field[3:0]),
    .size(size),
    .pc_data(1'b0),
    .scaled(scaled4)
  ); // RULE_05

  // byte displacement shared by base and pc data modes
  disp_scaler #(
    .IN_W(DISP8_W)
  ) scale_byte (
    .disp(disp_field[7:0]),
    .size(size),
    .pc_data(pc_data_mode),
    .scaled(scaled8)
  ); // RULE_07 RULE_09

  // branch offsets are signed and always doubled
  assign branch8 = {{23{disp_field[7]}}, disp_field[7:0], 1'b0}; // RULE_11
  assign branch12 = {{19{disp_field[11]}}, disp_field, 1'b0}; // RULE_12

  // longword table reads must stay aligned, so drop the low pc bits
  assign pc_base = (size == SIZE_LONG) ? (pc & LONG_ALIGN_MASK) : pc; // RULE_10

  load_extender extend (
    .data(load_data),
    .size(load_size),
    .ext(load_ext)
  );

  // ****************************************
  // address formation
  // ****************************************
  logic [31:0] address_next;
  logic mem_access_next;
  logic branch_next;

  // all sums are 32 bits wide and simply wrap, no overflow kept
  always_comb
  begin
    address_next = RESULT_RESET;
    mem_access_next = 1'b1;
    branch_next = 1'b0;
    case (mode)
      MODE_DIRECT: mem_access_next = 1'b0; // RULE_01
      MODE_INDIRECT: address_next = selected_general_register; // RULE_02
      MODE_POSTINC: address_next = selected_general_register; // RULE_03
      MODE_PREDEC: address_next = selected_general_register - step; // RULE_04 RULE_18
      MODE_REG_DISP: address_next = selected_general_register + scaled4; // RULE_05 RULE_18
      MODE_REG_INDEXED:
        address_next = selected_general_register + index_register_zero; // RULE_06
      MODE_BASE_DISP: address_next = global_base_register + scaled8; // RULE_07
      MODE_BASE_INDEXED:
        address_next = global_base_register + index_register_zero; // RULE_08
      MODE_PC_DATA: address_next = pc_base + scaled8; // RULE_09 RULE_10
      MODE_BRANCH_SHORT:
      begin
        address_next = pc + branch8; // RULE_11
        mem_access_next = 1'b0;
        branch_next = 1'b1;
      end
      MODE_BRANCH_LONG:
      begin
        address_next = pc + branch12; // RULE_12
        mem_access_next = 1'b0;
        branch_next = 1'b1;
      end
      MODE_BRANCH_REG:
      begin
        address_next = pc + selected_general_register; // RULE_13
        mem_access_next = 1'b0;
        branch_next = 1'b1;
      end
      default: mem_access_next = 1'b0;
    endcase
  end

  // ****************************************
  // operand formation
  // ****************************************
  logic [31:0] operand_next;
  logic operand_next_valid;

  // register and immediate operands that need no memory access
  always_comb
  begin
    operand_next = RESULT_RESET;
    operand_next_valid = 1'b1;
    case (mode)
      MODE_DIRECT: operand_next = selected_general_register; // RULE_01
      MODE_IMM_ZERO: operand_next = {24'h000000, imm_field}; // RULE_14
      MODE_IMM_SIGN: operand_next = {{24{imm_field[7]}}, imm_field}; // RULE_15
      MODE_IMM_TRAP:
        operand_next = {22'h0, imm_field, 2'b00}; // RULE_16
      default: operand_next_valid = 1'b0;
    endcase
  end

  // ****************************************
  // register update for auto modes
  // ****************************************
  logic [31:0] writeback_next;
  logic writeback_next_valid;

  // post-increment updates after use, pre-decrement stores the address
  always_comb
  begin
    writeback_next = RESULT_RESET;
    writeback_next_valid = 1'b1;
    case (mode)
      MODE_POSTINC: writeback_next = selected_general_register + step; // RULE_03 RULE_18
      MODE_PREDEC: writeback_next = selected_general_register - step; // RULE_04
      default: writeback_next_valid = 1'b0;
    endcase
  end

  // ****************************************
  // result registers
  // ****************************************
  logic result_valid_reg;
  logic mem_access_reg;
  logic branch_valid_reg;
  logic [31:0] address_reg;
  logic operand_valid_reg;
  logic [31:0] operand_reg;
  logic writeback_valid_reg;
  logic [31:0] writeback_value_reg;
  logic load_word_valid_reg;
  logic [31:0] load_word_reg;

  // strobes last one cycle per request
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      result_valid_reg <= 1'b0;
      mem_access_reg <= 1'b0;
      branch_valid_reg <= 1'b0;
      operand_valid_reg <= 1'b0;
      writeback_valid_reg <= 1'b0;
    end
    else
    begin
      result_valid_reg <= req_valid;
      mem_access_reg <= req_valid & mem_access_next;
      branch_valid_reg <= req_valid & branch_next;
      operand_valid_reg <= req_valid & operand_next_valid;
      writeback_valid_reg <= req_valid & writeback_next_valid;
    end
  end

  // values hold between requests so the consumer may sample late
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      address_reg <= RESULT_RESET;
      operand_reg <= RESULT_RESET;
      writeback_value_reg <= RESULT_RESET;
    end
    else if (req_valid)
    begin
      address_reg <= address_next;
      operand_reg <= operand_next;
      writeback_value_reg <= writeback_next;
    end
  end

  // load path is independent of the address path
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      load_word_valid_reg <= 1'b0;
      load_word_reg <= RESULT_RESET;
    end
    else
    begin
      load_word_valid_reg <= load_valid;
      if (load_valid)
        load_word_reg <= load_ext; // RULE_17
    end
  end

  assign result_valid = result_valid_reg;
  assign mem_access = mem_access_reg;
  assign branch_valid = branch_valid_reg;
  assign address = address_reg;
  assign operand_valid = operand_valid_reg;
  assign operand = operand_reg;
  assign writeback_valid = writeback_valid_reg;
  assign writeback_value = writeback_value_reg;
  assign load_word_valid = load_word_valid_reg;
  assign load_word = load_word_reg;

  // ****************************************
  // checks
  // ****************************************
  direct_operand_a: assert property (@(posedge clk) disable iff (reset) // RULE_01
    req_valid && mode == MODE_DIRECT |=>
      operand_valid && !mem_access &&
      operand == $past(selected_general_register))
    else $error("direct operand wrong");

  indirect_addr_a: assert property (@(posedge clk) disable iff (reset) // RULE_02
    req_valid && mode == MODE_INDIRECT |=>
      mem_access && address == $past(selected_general_register))
    else $error("indirect address wrong");

  postinc_long_a: assert property (@(posedge clk) disable iff (reset) // RULE_03
    req_valid && mode == MODE_POSTINC && size == SIZE_LONG |=>
      writeback_valid && address == $past(selected_general_register) &&
      writeback_value == address + 32'h0000_0004)
    else $error("post-increment long wrong");

  predec_word_a: assert property (@(posedge clk) disable iff (reset) // RULE_04
    req_valid && mode == MODE_PREDEC && size == SIZE_WORD |=>
      writeback_value == address &&
      address == $past(selected_general_register) - 32'h0000_0002)
    else $error("pre-decrement word wrong");

  reg_disp_a: assert property (@(posedge clk) disable iff (reset) // RULE_05
    req_valid && mode == MODE_REG_DISP && size == SIZE_LONG |=>
      address == $past(selected_general_register) +
        {26'h0, $past(disp_field[3:0]), 2'b00})
    else $error("register displacement wrong");

  base_index_a: assert property (@(posedge clk) disable iff (reset) // RULE_08
    req_valid && mode == MODE_BASE_INDEXED |=>
      address == $past(global_base_register) + $past(index_register_zero))
    else $error("indexed base wrong");

  pc_long_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
    req_valid && mode == MODE_PC_DATA && size == SIZE_LONG |=>
      address[1:0] == 2'b00 &&
      address == ($past(pc) & 32'hFFFF_FFFC) +
        {22'h0, $past(disp_field[7:0]), 2'b00})
    else $error("pc longword address wrong");

  short_branch_a: assert property (@(posedge clk) disable iff (reset) // RULE_11
    req_valid && mode == MODE_BRANCH_SHORT |=>
      branch_valid && !mem_access && address == $past(pc) +
        {{23{$past(disp_field[7])}}, $past(disp_field[7:0]), 1'b0})
    else $error("short branch target wrong");

  trap_offset_a: assert property (@(posedge clk) disable iff (reset) // RULE_16
    req_valid && mode == MODE_IMM_TRAP |=>
      operand[1:0] == 2'b00 && operand[31:10] == 22'h0 &&
      operand[9:2] == $past(imm_field))
    else $error("trap offset wrong");

  reg_index_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
    req_valid && mode == MODE_REG_INDEXED |=>
      mem_access && address == $past(selected_general_register) +
        $past(index_register_zero))
    else $error("indexed register address wrong");

  base_disp_a: assert property (@(posedge clk) disable iff (reset) // RULE_07
    req_valid && mode == MODE_BASE_DISP && size == SIZE_WORD |=>
      address == $past(global_base_register) +
        {23'h0, $past(disp_field[7:0]), 1'b0})
    else $error("base displacement wrong");

  pc_word_a: assert property (@(posedge clk) disable iff (reset) // RULE_09
    req_valid && mode == MODE_PC_DATA && size == SIZE_WORD |=>
      mem_access && address == $past(pc) +
        {23'h0, $past(disp_field[7:0]), 1'b0})
    else $error("pc word address wrong");

  long_branch_a: assert property (@(posedge clk) disable iff (reset) // RULE_12
    req_valid && mode == MODE_BRANCH_LONG |=>
      branch_valid && !mem_access && address == $past(pc) +
        {{19{$past(disp_field[11])}}, $past(disp_field), 1'b0})
    else $error("long branch target wrong");

  imm_sign_a: assert property (@(posedge clk) disable iff (reset) // RULE_15
    req_valid && mode == MODE_IMM_SIGN |=>
      operand_valid && !mem_access &&
      operand == {{24{$past(imm_field[7])}}, $past(imm_field)})
    else $error("signed immediate wrong");

  load_byte_a: assert property (@(posedge clk) disable iff (reset) // RULE_17
    load_valid && load_size == SIZE_BYTE |=>
      load_word_valid && load_word == {{24{$past(load_data[7])}},
        $past(load_data[7:0])})
    else $error("byte load extension wrong");

endmodule // effective_address_generator

/* File: gpr_model.sv */
// partner model: the general register file slot feeding the generator
// assumes the bench preloads it and the generator writes it back
`timescale 1ns/1ns
module gpr_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // preload from the bench
  input wire logic preset_valid,
  input wire logic [31:0] preset_value,
  // write back from the generator
  input wire logic writeback_valid,
  input wire logic [31:0] writeback_value,
  // register value towards the generator
  output logic [31:0] gpr_value
);
  // ****************************************
  // register storage
  // ****************************************
  // write back wins over preload, as a real file would not see both
  always_ff @(posedge clk)
  begin
    if (reset)
      gpr_value <= 32'h0000_0000;
    else if (writeback_valid)
      gpr_value <= writeback_value;
    else if (preset_valid)
      gpr_value <= preset_value;
  end
endmodule // gpr_model

/* File: effective_address_generator_bench.sv */
// self-checking bench for the effective address generator
// assumes eag_pkg is compiled first and gpr_model stands in for the file
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, got); \
    end \
  end
module effective_address_generator_bench;
  import eag_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  mode_t mode = MODE_DIRECT;
  size_t size = SIZE_BYTE;
  logic [11:0] disp_field = 12'h000;
  logic [7:0] imm_field = 8'h00;
  logic [31:0] gpr_value;
  logic [31:0] index_register_zero = 32'h0000_0000;
  logic [31:0] global_base_register = 32'h0000_0000;
  logic [31:0] pc = 32'h0000_0000;
  logic load_valid = 1'b0;
  size_t load_size = SIZE_BYTE;
  logic [31:0] load_data = 32'h0000_0000;
  logic preset_valid = 1'b0;
  logic [31:0] preset_value = 32'h0000_0000;
  logic result_valid, mem_access, branch_valid, operand_valid;
  logic writeback_valid, load_word_valid;
  logic [31:0] address, operand, writeback_value, load_word;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] lfsr_reg = 32'h0000_828E;

  always #10 clk = ~clk;

  // ****************************************
  // instances
  // ****************************************
  effective_address_generator effective_address_generator_i (
    .clk(clk), .reset(reset), .req_valid(req_valid), .mode(mode),
    .size(size), .disp_field(disp_field), .imm_field(imm_field),
    .selected_general_register(gpr_value),
    .index_register_zero(index_register_zero),
    .global_base_register(global_base_register), .pc(pc),
    .load_valid(load_valid), .load_size(load_size),
    .load_data(load_data), .result_valid(result_valid),
    .mem_access(mem_access), .branch_valid(branch_valid),
    .address(address), .operand_valid(operand_valid),
    .operand(operand), .writeback_valid(writeback_valid),
    .writeback_value(writeback_value),
    .load_word_valid(load_word_valid), .load_word(load_word));

  gpr_model gpr_model_i (
    .clk(clk), .reset(reset), .preset_valid(preset_valid),
    .preset_value(preset_value), .writeback_valid(writeback_valid),
    .writeback_value(writeback_value), .gpr_value(gpr_value));

  // ****************************************
  // helpers
  // ****************************************
  // repeatable stimulus: same seed gives the same run every time
  function automatic logic [31:0] lfsr_step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic get_rand(output logic [31:0] v);
    lfsr_reg = lfsr_step(lfsr_reg);
    v = lfsr_reg;
  endtask

  // expected address or operand, worked out independently of the design
  function automatic logic [31:0] calc(mode_t m, size_t s,
    logic [11:0] d, logic [7:0] im, logic [31:0] r, logic [31:0] r0,
    logic [31:0] g, logic [31:0] p);
    logic [31:0] st;
    st = s == SIZE_BYTE ? STEP_BYTE : s == SIZE_WORD ? STEP_WORD : STEP_LONG;
    case (m)
      MODE_DIRECT, MODE_INDIRECT, MODE_POSTINC: calc = r;
      MODE_PREDEC: calc = r - st;
      MODE_REG_DISP: calc = r + {28'h0, d[3:0]} * st;
      MODE_REG_INDEXED: calc = r + r0;
      MODE_BASE_DISP: calc = g + {24'h0, d[7:0]} * st;
      MODE_BASE_INDEXED: calc = g + r0;
      MODE_PC_DATA: calc = s == SIZE_LONG ?
        (p & 32'hFFFF_FFFC) + {22'h0, d[7:0], 2'h0} :
        p + {23'h0, d[7:0], 1'h0};
      MODE_BRANCH_SHORT: calc = p + {{23{d[7]}}, d[7:0], 1'h0};
      MODE_BRANCH_LONG: calc = p + {{19{d[11]}}, d, 1'h0};
      MODE_BRANCH_REG: calc = p + r;
      MODE_IMM_ZERO: calc = {24'h0, im};
      MODE_IMM_SIGN: calc = {{24{im[7]}}, im};
      MODE_IMM_TRAP: calc = {22'h0, im, 2'h0};
      default: calc = 32'h0000_0000;
    endcase
  endfunction

  // one mode over all sizes, with wrap-around corners first
  task automatic run(input mode_t m);
    logic [31:0] rv, r0v, gv, pv, dv, iv, ex, wb, st;
    size_t s;
    logic opm, brm, wbm, memm;
    for (int i = 0; i < 9; i++)
    begin
      s = size_t'(i % 3);
      get_rand(rv);
      get_rand(r0v);
      get_rand(gv);
      get_rand(pv);
      get_rand(dv);
      get_rand(iv);
      if (i < 3)
      begin
        rv = 32'hFFFF_FFFE;
        pv = 32'hFFFF_FFFF;
        gv = 32'hFFFF_FFF0;
        dv = 32'h0000_0FFF;
        iv = 32'h0000_00FF;
      end
      else if (i < 6)
      begin
        rv = 32'h0000_0000;
        pv = 32'h0000_0002;
        dv = 32'h0000_0880;
        iv = 32'h0000_0080;
      end
      st = s == SIZE_BYTE ? STEP_BYTE :
        s == SIZE_WORD ? STEP_WORD : STEP_LONG;
      ex = calc(m, s, dv[11:0], iv[7:0], rv, r0v, gv, pv);
      wb = (m == MODE_PREDEC) ? rv - st : rv + st;
      opm = m inside {MODE_DIRECT, MODE_IMM_ZERO, MODE_IMM_SIGN,
        MODE_IMM_TRAP};
      brm = m inside {MODE_BRANCH_SHORT, MODE_BRANCH_LONG, MODE_BRANCH_REG};
      wbm = m inside {MODE_POSTINC, MODE_PREDEC};
      memm = m inside {MODE_INDIRECT, MODE_POSTINC, MODE_PREDEC,
        MODE_REG_DISP, MODE_REG_INDEXED, MODE_BASE_DISP,
        MODE_BASE_INDEXED, MODE_PC_DATA};
      @(posedge clk);
      preset_valid <= 1'b1;
      preset_value <= rv;
      @(posedge clk);
      preset_valid <= 1'b0;
      req_valid <= 1'b1;
      mode <= m;
      size <= s;
      disp_field <= dv[11:0];
      imm_field <= iv[7:0];
      index_register_zero <= r0v;
      global_base_register <= gv;
      pc <= pv;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      `CHK("result_valid", 1'b1, result_valid);
      `CHK("mem_access", memm, mem_access);
      `CHK("branch_valid", brm, branch_valid);
      `CHK("operand_valid", opm, operand_valid);
      `CHK("writeback_valid", wbm, writeback_valid);
      if (opm)
      begin
        `CHK("operand", ex, operand);
      end
      else if (memm || brm)
      begin
        `CHK("address", ex, address);
      end
      if (wbm)
        `CHK("writeback_value", wb, writeback_value);
      @(posedge clk);
      #1;
      `CHK("result_valid low", 1'b0, result_valid);
      // the partner register must now hold the stepped value
      if (wbm)
        `CHK("register after", wb, gpr_value);
    end
  endtask

  task automatic load_chk(input size_t s, input logic [31:0] dat);
    logic [31:0] ex;
    ex = s == SIZE_BYTE ? {{24{dat[7]}}, dat[7:0]} :
      s == SIZE_WORD ? {{16{dat[15]}}, dat[15:0]} : dat;
    @(posedge clk);
    load_valid <= 1'b1;
    load_size <= s;
    load_data <= dat;
    @(posedge clk);
    load_valid <= 1'b0;
    #1;
    `CHK("load_word_valid", 1'b1, load_word_valid);
    `CHK("load_word", ex, load_word);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] v;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("address after reset", 32'h0000_0000, address);
    run(MODE_DIRECT);
    run(MODE_INDIRECT);
    run(MODE_POSTINC);
    run(MODE_PREDEC);
    run(MODE_REG_DISP);
    run(MODE_REG_INDEXED);
    run(MODE_BASE_DISP);
    run(MODE_BASE_INDEXED);
    run(MODE_PC_DATA);
    run(MODE_BRANCH_SHORT);
    run(MODE_BRANCH_LONG);
    run(MODE_BRANCH_REG);
    run(MODE_IMM_ZERO);
    run(MODE_IMM_SIGN);
    run(MODE_IMM_TRAP);
    run(mode_t'(4'hF));
    for (int i = 0; i < 9; i++)
    begin
      get_rand(v);
      if (i < 3)
        v = 32'h0000_8080;
      else if (i < 6)
        v = 32'hFFFF_7F7F;
      load_chk(size_t'(i % 3), v);
    end
    // mid-run reset: address, writeback value, load word and result_valid must clear
    run(MODE_PREDEC);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("address cleared", 32'h0000_0000, address);
    `CHK("writeback cleared", 32'h0000_0000, writeback_value);
    `CHK("load_word cleared", 32'h0000_0000, load_word);
    `CHK("result_valid cleared", 1'b0, result_valid);
    run(MODE_BASE_DISP);
    summarize();
  end

  // watchdog: the tests need some 700 cycles, so 20000 means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule // effective_address_generator_bench
